// File: ufc_map.vh
`ifndef UFC_MAP_VH
`define UFC_MAP_VH

// ****************************************************
// Register byte offsets
// ****************************************************
`define UFC_OFS_FIFO_CTRL   12'h000
`define UFC_OFS_SER_CTRL    12'h004
`define UFC_OFS_OCCUPANCY   12'h008
`define UFC_OFS_PORT_CTRL   12'h00C
`define UFC_OFS_LINE_STAT   12'h010

// ****************************************************
// Field positions
// ****************************************************
`define UFC_FC_MCE          3
`define UFC_FC_TFRST        2
`define UFC_FC_RFRST        1
`define UFC_SC_TE           5
`define UFC_SC_RE           4
`define UFC_SC_CLK_SOURCE_SEL_HI         1
`define UFC_SC_CLK_SOURCE_SEL_LO         0
`define UFC_OC_TX_LSB       8
`define UFC_OC_RX_LSB       0
`define UFC_PT_RTS_DIR      7
`define UFC_PT_RTS_DATA     6
`define UFC_PT_CTS_DIR      5
`define UFC_PT_CTS_DATA     4
`define UFC_PT_CLK_DIR      3
`define UFC_PT_CLK_DATA     2
`define UFC_PT_BRK_DIR      1
`define UFC_PT_BRK_DATA     0
`define UFC_LS_OVERRUN_FLAG         0

// ****************************************************
// Reset values and sizes
// ****************************************************
`define UFC_RST_FIFO_CTRL   4'h0
`define UFC_RST_SER_CTRL    6'h00
`define UFC_RST_PORT_DIR    4'h0
`define UFC_RST_OVERRUN_FLAG        1'b0
`define UFC_FIFO_DEPTH      16
`define UFC_COUNT_W         5

`endif

// File: ufc_occ_count.v
`timescale 1ns/100ps
`include "ufc_map.vh"

module ufc_occ_count #(
   parameter DEPTH   = `UFC_FIFO_DEPTH,
   parameter COUNT_W = `UFC_COUNT_W
) (
   // Clock and reset
   input  wire               pclk,
   input  wire               presetn,
   // Events
   input  wire               clr,
   input  wire               push,
   input  wire               pop,
   // State
   output reg  [COUNT_W-1:0] count_reg,
   output wire               full,
   output wire               empty
);

   localparam [COUNT_W-1:0] FULL_CNT = DEPTH[COUNT_W-1:0];
   localparam [COUNT_W-1:0] ONE      = {{(COUNT_W-1){1'b0}}, 1'b1};

   reg  [COUNT_W-1:0] count_next;
   wire               do_push;
   wire               do_pop;

   assign full    = (count_reg == FULL_CNT);
   assign empty   = (count_reg == {COUNT_W{1'b0}});
   // Overfill and underflow are refused so the count stays in range;
   // a push and a pop in one cycle pass through and leave the count as is
   assign do_push = push & (~full | pop);
   assign do_pop  = pop & (~empty | push);

   always @* begin
      count_next = count_reg;
      if (clr) begin
         count_next = {COUNT_W{1'b0}};                // see RULE24
      end else if (do_push & ~do_pop) begin
         count_next = count_reg + ONE;                // see RULE24
      end else if (do_pop & ~do_push) begin
         count_next = count_reg - ONE;                // see RULE24
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= {COUNT_W{1'b0}};
      end else begin
         count_reg <= count_next;
      end
   end

endmodule

// File: ufc_serial_aux.v
// Summary of operation
// RULE1: occupancy word: tx count high, rx low
// RULE2: tx count bits 12:8, zero to sixteen
// RULE3: rx count bits 4:0, zero to sixteen
// RULE4: occupancy read-only, reset zero, spare bits zero
// RULE5: reset clears port bits except pin data
// RULE6: port bits 15:8 read zero
// RULE7: rts direction set drives rts data
// RULE8: rts data reads rts pin level
// RULE9: cts direction set drives cts data
// RULE10: cts data reads cts pin level
// RULE11: clear modem enable before port rts/cts
// RULE12: clock direction set drives clock data
// RULE13: clock data reads clock pin level
// RULE14: break direction set drives transmit pin
// RULE15: break data reads receive pin level
// RULE16: pin data low is 0, high 1
// RULE17: character on full rx fifo sets overrun
// RULE18: overrun clears by reset or read-1-write-0
// RULE19: receive disable keeps overrun flag
// RULE20: overrun keeps fifo, drops character, halts
// RULE21: line status bits 15:1 read zero
// RULE22: modem off: cts asserted, rts zero
// RULE23: each fifo holds sixteen bytes
// RULE24: counts follow pushes, pops, fifo reset
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "ufc_map.vh"

module ufc_serial_aux #(
   parameter DEPTH   = `UFC_FIFO_DEPTH,
   parameter COUNT_W = `UFC_COUNT_W
) (
   // APB clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // Transmit FIFO events
   input  wire        tx_push,
   input  wire        tx_pop,
   output wire        tx_full,
   // Receive FIFO events
   input  wire        rx_char_done,
   input  wire        rx_pop,
   output wire        rx_store,
   output wire        rx_enable,
   output wire        rx_full,
   // Serial engine side
   input  wire        tx_line,
   input  wire        rts_modem,
   input  wire        baud_clk,
   output wire        cts_ok,
   output wire        tx_enable,
   // Request-to-send pin
   input  wire        rts_pin_i,
   output wire        rts_pin_o,
   output wire        rts_pin_oe,
   // Clear-to-send pin
   input  wire        cts_pin_i,
   output wire        cts_pin_o,
   output wire        cts_pin_oe,
   // Serial clock pin
   input  wire        sck_pin_i,
   output wire        sck_pin_o,
   output wire        sck_pin_oe,
   // Transmit and receive pins
   input  wire        rxd_pin_i,
   output wire        txd_pin_o,
   output wire        txd_pin_oe
);

   // ****************************************************
   // Declarations
   // ****************************************************
   reg  [3:0]         fifo_ctrl_reg;
   reg  [5:0]         ser_ctrl_reg;
   reg  [3:0]         port_dir_reg;
   reg  [3:0]         pin_data_reg;
   reg                overrun_flag_reg;
   reg                overrun_flag_next;
   reg                overrun_seen_reg;
   reg                overrun_seen_next;
   reg  [31:0]        rdata_next;
   reg                addr_hit;
   wire               setup_ph;
   wire               access_ph;
   wire               wr_en;
   wire               rd_en;
   wire               modem_ctrl_enable;
   wire               tx_fifo_rst;
   wire               rx_fifo_rst;
   wire               transmit_enable_bit;
   wire               receive_enable_bit;
   wire [1:0]         clk_source_sel;
   wire [COUNT_W-1:0] tx_count;
   wire [COUNT_W-1:0] rx_count;
   wire               rx_fifo_full;
   wire               overrun_event;
   wire               rx_push;
   wire [15:0]        occ_word;
   wire [15:0]        port_word;
   wire [15:0]        lsr_word;
   wire               rts_pin_dir;
   wire               cts_pin_dir;
   wire               clk_pin_dir;
   wire               break_pin_dir;

   // ****************************************************
   // APB handshake
   // ****************************************************
   // Zero wait states: the read word is captured in setup
   assign setup_ph  = psel & ~penable;
   assign access_ph = psel & penable;
   assign wr_en     = access_ph & pwrite & addr_hit;
   assign rd_en     = access_ph & ~pwrite & addr_hit;
   assign pready    = 1'b1;
   assign pslverr   = access_ph & ~addr_hit;

   always @* begin
      case (paddr)
         `UFC_OFS_FIFO_CTRL: addr_hit = 1'b1;
         `UFC_OFS_SER_CTRL:  addr_hit = 1'b1;
         `UFC_OFS_OCCUPANCY: addr_hit = 1'b1;
         `UFC_OFS_PORT_CTRL: addr_hit = 1'b1;
         `UFC_OFS_LINE_STAT: addr_hit = 1'b1;
         default:            addr_hit = 1'b0;
      endcase
   end

   // ****************************************************
   // Control field decode
   // ****************************************************
   assign modem_ctrl_enable   = fifo_ctrl_reg[`UFC_FC_MCE];
   assign tx_fifo_rst         = fifo_ctrl_reg[`UFC_FC_TFRST];
   assign rx_fifo_rst         = fifo_ctrl_reg[`UFC_FC_RFRST];
   assign transmit_enable_bit = ser_ctrl_reg[`UFC_SC_TE];
   assign receive_enable_bit  = ser_ctrl_reg[`UFC_SC_RE];
   assign clk_source_sel      = {ser_ctrl_reg[`UFC_SC_CLK_SOURCE_SEL_HI],
                                 ser_ctrl_reg[`UFC_SC_CLK_SOURCE_SEL_LO]};
   assign rts_pin_dir         = port_dir_reg[3];
   assign cts_pin_dir         = port_dir_reg[2];
   assign clk_pin_dir         = port_dir_reg[1];
   assign break_pin_dir       = port_dir_reg[0];
   assign tx_enable           = transmit_enable_bit;

   // ****************************************************
   // Control registers
   // ****************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_ctrl_reg <= `UFC_RST_FIFO_CTRL;
         ser_ctrl_reg  <= `UFC_RST_SER_CTRL;
         port_dir_reg  <= `UFC_RST_PORT_DIR;           // see RULE5
      end else if (wr_en) begin
         if (paddr == `UFC_OFS_FIFO_CTRL) begin
            fifo_ctrl_reg <= pwdata[3:0];
         end
         if (paddr == `UFC_OFS_SER_CTRL) begin
            ser_ctrl_reg <= pwdata[5:0];
         end
         if (paddr == `UFC_OFS_PORT_CTRL) begin
            port_dir_reg <= {pwdata[`UFC_PT_RTS_DIR],
                             pwdata[`UFC_PT_CTS_DIR],
                             pwdata[`UFC_PT_CLK_DIR],
                             pwdata[`UFC_PT_BRK_DIR]};
         end
      end
   end

   // Pin data latches have no reset: their value is undefined until written
   always @(posedge pclk) begin
      if (wr_en && (paddr == `UFC_OFS_PORT_CTRL)) begin
         pin_data_reg <= {pwdata[`UFC_PT_RTS_DATA],
                          pwdata[`UFC_PT_CTS_DATA],
                          pwdata[`UFC_PT_CLK_DATA],
                          pwdata[`UFC_PT_BRK_DATA]};   // see RULE5
      end
   end

   // ****************************************************
   // FIFO occupancy counters
   // ****************************************************
   // Sixteen stages bound each count at sixteen
   ufc_occ_count #(
      .DEPTH   (DEPTH),
      .COUNT_W (COUNT_W)
   ) u_tx_count (
      .pclk      (pclk),
      .presetn   (presetn),
      .clr       (tx_fifo_rst),
      .push      (tx_push),
      .pop       (tx_pop),
      .count_reg (tx_count),
      .full      (tx_full),
      .empty     ()
   );                                                 // see RULE23

   ufc_occ_count #(
      .DEPTH   (DEPTH),
      .COUNT_W (COUNT_W)
   ) u_rx_count (
      .pclk      (pclk),
      .presetn   (presetn),
      .clr       (rx_fifo_rst),
      .push      (rx_push),
      .pop       (rx_pop),
      .count_reg (rx_count),
      .full      (rx_fifo_full),
      .empty     ()
   );                                                 // see RULE23

   assign rx_full = rx_fifo_full;

   // ****************************************************
   // Receive gating and overrun
   // ****************************************************
   // A character that lands on a full FIFO is lost, older bytes stay
   assign rx_enable     = receive_enable_bit & ~overrun_flag_reg;    // see RULE20
   assign overrun_event = rx_char_done & rx_enable & rx_fifo_full;   // see RULE17
   assign rx_push       = rx_char_done & rx_enable & ~rx_fifo_full;  // see RULE20
   assign rx_store      = rx_push;

   always @* begin
      overrun_flag_next = overrun_flag_reg;
      overrun_seen_next = overrun_seen_reg;
      // Reading the flag as 1 arms the write-0 clear
      if (rd_en && (paddr == `UFC_OFS_LINE_STAT) && overrun_flag_reg) begin
         overrun_seen_next = 1'b1;                              // see RULE18
      end
      // Writing 1, or 0 without a prior read of 1, does nothing
      if (wr_en && (paddr == `UFC_OFS_LINE_STAT) && overrun_seen_reg &&
          !pwdata[`UFC_LS_OVERRUN_FLAG]) begin
         overrun_flag_next = 1'b0;                              // see RULE18
         overrun_seen_next = 1'b0;
      end
      // A new overrun in the clearing cycle wins over the clear
      if (overrun_event) begin
         overrun_flag_next = 1'b1;                              // see RULE17
      end
   end

   // Receive enable is not a term here, so clearing it keeps the flag
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overrun_flag_reg <= `UFC_RST_OVERRUN_FLAG;                     // see RULE18
         overrun_seen_reg <= 1'b0;
      end else begin
         overrun_flag_reg <= overrun_flag_next;                 // see RULE19
         overrun_seen_reg <= overrun_seen_next;
      end
   end

   // ****************************************************
   // Pin drivers
   // ****************************************************
   // Port output overrides modem logic; software clears the modem
   // enable first, otherwise the pin shows the port value anyway
   assign rts_pin_oe = rts_pin_dir | modem_ctrl_enable;         // see RULE7
   assign rts_pin_o  = rts_pin_dir ? pin_data_reg[3] :
                       (modem_ctrl_enable & rts_modem);         // see RULE22
   assign cts_pin_oe = cts_pin_dir;                             // see RULE9
   assign cts_pin_o  = pin_data_reg[2];                         // see RULE16
   // Active-low clear-to-send is forced asserted with modem off
   assign cts_ok     = modem_ctrl_enable ? ~cts_pin_i : 1'b1;   // see RULE22

   // Internal clock output is the only non-port driver of the clock pin
   assign sck_pin_oe = clk_pin_dir | (clk_source_sel == 2'b01); // see RULE12
   assign sck_pin_o  = clk_pin_dir ? pin_data_reg[1] :
                       baud_clk;                                // see RULE12

   // Break output overrides the transmitter; idle line is mark
   assign txd_pin_oe = break_pin_dir | transmit_enable_bit;     // see RULE14
   assign txd_pin_o  = break_pin_dir ? pin_data_reg[0] :
                       (transmit_enable_bit ? tx_line : 1'b1);  // see RULE14

   // ****************************************************
   // Read words
   // ****************************************************
   assign occ_word = {3'h0, tx_count, 3'h0, rx_count};          // see RULE1
   assign port_word = {8'h00,                                   // see RULE6
                       rts_pin_dir, rts_pin_i,                  // see RULE8
                       cts_pin_dir, cts_pin_i,                  // see RULE10
                       clk_pin_dir, sck_pin_i,                  // see RULE13
                       break_pin_dir, rxd_pin_i};               // see RULE15
   assign lsr_word = {15'h0000, overrun_flag_reg};              // see RULE21

   always @* begin
      case (paddr)
         `UFC_OFS_FIFO_CTRL: rdata_next = {28'h0000000, fifo_ctrl_reg};
         `UFC_OFS_SER_CTRL:  rdata_next = {26'h0, ser_ctrl_reg};
         `UFC_OFS_OCCUPANCY: rdata_next = {16'h0000, occ_word}; // see RULE2
         `UFC_OFS_PORT_CTRL: rdata_next = {16'h0000, port_word};
         `UFC_OFS_LINE_STAT: rdata_next = {16'h0000, lsr_word};
         default:            rdata_next = 32'h00000000;
      endcase
   end

   // Occupancy has no write path, so writes to it are dropped
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;                                // see RULE4
      end else if (setup_ph && !pwrite) begin
         prdata <= rdata_next;                                  // see RULE3
      end
   end

endmodule

// File: ufc_remote.sv
`timescale 1ns/100ps
// ************************************************
// Remote serial device on the pins
// ************************************************
module ufc_remote (
   // Device drives
   input  wire       rts_pin_o,
   input  wire       rts_pin_oe,
   input  wire       cts_pin_o,
   input  wire       cts_pin_oe,
   input  wire       sck_pin_o,
   input  wire       sck_pin_oe,
   input  wire       txd_pin_o,
   input  wire       txd_pin_oe,
   // Levels put on cts, sck and rxd
   input  wire [2:0] drive_lvl,
   // Resolved line levels
   output wire       rts_line,
   output wire       cts_line,
   output wire       sck_line,
   output wire       rxd_line,
   output wire       txd_line
);
   // Backs off where the device drives; undriven rts and txd sit on pull-ups
   assign rts_line = rts_pin_oe ? rts_pin_o : 1'b1;
   assign cts_line = cts_pin_oe ? cts_pin_o : drive_lvl[2];
   assign sck_line = sck_pin_oe ? sck_pin_o : drive_lvl[1];
   assign rxd_line = drive_lvl[0];
   assign txd_line = txd_pin_oe ? txd_pin_o : 1'b1;
endmodule

// File: ufc_serial_aux_checker.sv
`timescale 1ns/100ps
`include "ufc_map.vh"
// ************************************************
// Port-level checks
// ************************************************
module ufc_serial_aux_checker #(
   parameter DEPTH   = 16,
   parameter COUNT_W = 5
) (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire        tx_push,
   input wire        tx_full,
   input wire        rx_char_done,
   input wire        rx_store,
   input wire        rx_enable,
   input wire        rx_full,
   input wire        cts_ok,
   input wire        rts_pin_oe,
   input wire        cts_pin_oe,
   input wire        txd_pin_oe,
   input wire        rts_pin_i,
   input wire        cts_pin_i,
   input wire        sck_pin_i,
   input wire        rxd_pin_i
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire wr_acc = psel && penable && pwrite;
   wire ovr_ev = rx_char_done && rx_full && rx_enable;
   wire pt_rd  = psel && !penable && !pwrite && (paddr == `UFC_OFS_PORT_CTRL);

   property p_ovr_set; ovr_ev |=> !rx_enable; endproperty
   a_ovr_set: assert property (p_ovr_set) else $error("overrun left reception on");
   property p_drop; rx_char_done && (rx_full || !rx_enable) |-> !rx_store; endproperty
   a_drop: assert property (p_drop) else $error("character stored while blocked");
   property p_hold; !rx_enable && !wr_acc |=> !rx_enable; endproperty
   a_hold: assert property (p_hold) else $error("reception resumed without write");
   property p_rx_rise; $rose(rx_full) |-> $past(rx_store); endproperty
   a_rx_rise: assert property (p_rx_rise) else $error("rx full without store");
   property p_tx_rise; $rose(tx_full) |-> $past(tx_push); endproperty
   a_tx_rise: assert property (p_tx_rise) else $error("tx full without push");
   property p_upper; psel && penable && !pwrite |-> prdata[31:16] == 16'h0000; endproperty
   a_upper: assert property (p_upper) else $error("upper read bits not zero");
   property p_pins;
      pt_rd |=> prdata[6] == $past(rts_pin_i) && prdata[4] == $past(cts_pin_i)
         && prdata[2] == $past(sck_pin_i) && prdata[0] == $past(rxd_pin_i);
   endproperty
   a_pins: assert property (p_pins) else $error("port read differs from pins");
   property p_oe; !wr_acc |=> $stable(cts_pin_oe) && $stable(txd_pin_oe); endproperty
   a_oe: assert property (p_oe) else $error("pin enable moved without write");
   property p_cts_ok; !rts_pin_oe |-> cts_ok; endproperty
   a_cts_ok: assert property (p_cts_ok) else $error("cts not forced on");
   c_ovr: cover property (ovr_ev);
   c_pins: cover property (pt_rd);
   c_txf: cover property ($rose(tx_full));
endmodule
bind ufc_serial_aux ufc_serial_aux_checker #(.DEPTH(DEPTH), .COUNT_W(COUNT_W)) u_chk (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .tx_push, .tx_full,
   .rx_char_done, .rx_store, .rx_enable, .rx_full, .cts_ok, .rts_pin_oe, .cts_pin_oe,
   .txd_pin_oe, .rts_pin_i, .cts_pin_i, .sck_pin_i, .rxd_pin_i
);

// File: ufc_serial_aux_tb.sv
`timescale 1ns/100ps
`include "ufc_map.vh"
module ufc_serial_aux_tb;
   typedef struct packed {
      logic [7:0] wr;
      logic [2:0] lvl;
      logic [7:0] rd;
      logic [3:0] oe;
      logic [3:0] lv;
   } ufc_row_t;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd;
   logic        tx_push = 1'b0, tx_pop = 1'b0, rx_char_done = 1'b0, rx_pop = 1'b0, slv;
   logic        tx_line = 1'b1, rts_modem = 1'b0, baud_clk = 1'b0;
   logic [2:0]  lvl = 3'h0;
   wire  [31:0] prdata;
   wire         pready, pslverr, tx_full, rx_store, rx_enable, rx_full, cts_ok, tx_enable;
   wire         rts_pin_o, rts_pin_oe, cts_pin_o, cts_pin_oe, sck_pin_o, sck_pin_oe;
   wire         txd_pin_o, txd_pin_oe, rts_line, cts_line, sck_line, rxd_line, txd_line;
   int          num_errors = 0, compares = 0, cycles = 0;
   // Port rows: write, remote levels {cts,sck,rxd}, read, enables and levels {rts,cts,sck,txd}
   ufc_row_t rows [5] = '{'{8'h00, 3'h0, 8'h40, 4'h0, 4'h9}, '{8'h00, 3'h7, 8'h55, 4'h0, 4'hF},
      '{8'hAA, 3'h7, 8'hAB, 4'hF, 4'h0}, '{8'hFF, 3'h0, 8'hFE, 4'hF, 4'hF},
      '{8'h55, 3'h2, 8'h44, 4'h0, 4'hB}};

   ufc_serial_aux uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .tx_push, .tx_pop, .tx_full, .rx_char_done, .rx_pop, .rx_store,
      .rx_enable, .rx_full, .tx_line, .rts_modem, .baud_clk, .cts_ok, .tx_enable,
      .rts_pin_i(rts_line), .rts_pin_o, .rts_pin_oe, .cts_pin_i(cts_line), .cts_pin_o,
      .cts_pin_oe, .sck_pin_i(sck_line), .sck_pin_o, .sck_pin_oe, .rxd_pin_i(rxd_line),
      .txd_pin_o, .txd_pin_oe);
   ufc_remote u_remote (.rts_pin_o, .rts_pin_oe, .cts_pin_o, .cts_pin_oe, .sck_pin_o,
      .sck_pin_oe, .txd_pin_o, .txd_pin_oe, .drive_lvl(lvl), .rts_line, .cts_line,
      .sck_line, .rxd_line, .txd_line);

   always #50 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         num_errors++;
         report_and_stop;
      end
   end

   task report_and_stop;
      if (num_errors == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One transfer; held until pready is sampled high
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d = 32'h0);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task ev(input logic [3:0] w, input int n);
      repeat (n) begin
         @(posedge pclk) {tx_push, tx_pop, rx_char_done, rx_pop} <= w;
         @(posedge pclk) {tx_push, tx_pop, rx_char_done, rx_pop} <= 4'h0;
      end
   endtask

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, `UFC_OFS_OCCUPANCY); chk("occupancy", 32'h0, rd);
      apb(0, `UFC_OFS_LINE_STAT); chk("line status", 32'h0, rd);
      apb(0, `UFC_OFS_PORT_CTRL); chk("port", 32'h40, rd);
      chk("enables", 32'h0, {rts_pin_oe, cts_pin_oe, sck_pin_oe, txd_pin_oe});
      apb(1, `UFC_OFS_OCCUPANCY, 32'h1F1F);
      apb(0, `UFC_OFS_OCCUPANCY); chk("occupancy", 32'h0, rd);
      apb(0, 12'hFFC); chk("slverr", 32'h1, slv);
      foreach (rows[i]) begin
         lvl <= rows[i].lvl;
         apb(1, `UFC_OFS_PORT_CTRL, {24'h0, rows[i].wr});
         apb(0, `UFC_OFS_PORT_CTRL); chk("port", {24'h0, rows[i].rd}, rd);
         chk("enables", rows[i].oe, {rts_pin_oe, cts_pin_oe, sck_pin_oe, txd_pin_oe});
         chk("levels", rows[i].lv, {rts_line, cts_line, sck_line, txd_line});
      end
      // Receive on, transmit off, internal clock with no pin output
      apb(1, `UFC_OFS_SER_CTRL, 32'h10);
      ev(4'h8, 17);
      ev(4'h2, 16);
      apb(0, `UFC_OFS_OCCUPANCY); chk("occupancy", 32'h1010, rd);
      chk("full", 32'h3, {tx_full, rx_full});
      ev(4'h2, 2);
      apb(0, `UFC_OFS_OCCUPANCY); chk("occupancy", 32'h1010, rd);
      chk("rx enable", 32'h0, rx_enable);
      apb(1, `UFC_OFS_LINE_STAT, 32'h0);
      apb(1, `UFC_OFS_SER_CTRL, 32'h0);
      apb(0, `UFC_OFS_LINE_STAT); chk("overrun", 32'h1, rd);
      apb(1, `UFC_OFS_LINE_STAT, 32'h1);
      apb(0, `UFC_OFS_LINE_STAT); chk("overrun", 32'h1, rd);
      apb(1, `UFC_OFS_LINE_STAT, 32'h0);
      apb(0, `UFC_OFS_LINE_STAT); chk("overrun", 32'h0, rd);
      ev(4'hD, 1);
      ev(4'h4, 3);
      apb(0, `UFC_OFS_OCCUPANCY); chk("occupancy", 32'h0D0F, rd);
      apb(1, `UFC_OFS_FIFO_CTRL, 32'h4);
      apb(0, `UFC_OFS_OCCUPANCY); chk("occupancy", 32'h000F, rd);
      // Modem logic on, then off; transmitter and internal clock on the pins
      lvl <= 3'h4;
      rts_modem <= 1'b0;
      tx_line <= 1'b0;
      baud_clk <= 1'b1;
      apb(1, `UFC_OFS_FIFO_CTRL, 32'h8);
      apb(0, `UFC_OFS_FIFO_CTRL); chk("fifo ctrl", 32'h8, rd);
      chk("modem pins", 32'h0, {rts_line, cts_ok});
      apb(1, `UFC_OFS_FIFO_CTRL, 32'h0);
      apb(1, `UFC_OFS_SER_CTRL, 32'h21);
      apb(0, `UFC_OFS_SER_CTRL); chk("serial ctrl", 32'h21, rd);
      chk("modem off", 32'h3, {rts_line, cts_ok});
      chk("engine pins", 32'h5, {sck_line, txd_line, tx_enable});
      @(posedge pclk) presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, `UFC_OFS_OCCUPANCY); chk("occupancy", 32'h0, rd);
      report_and_stop;
   end
endmodule
